// File: sfepd_consts.vh
`ifndef SFEPD_CONSTS_VH
`define SFEPD_CONSTS_VH

// opcodes
`define SFEPD_OP_LATCH_SET 8'h06
`define SFEPD_OP_SMALL_WIPE 8'h52
`define SFEPD_OP_LARGE_WIPE 8'hD8
`define SFEPD_OP_WHOLE_WIPE_A 8'h60
`define SFEPD_OP_WHOLE_WIPE_B 8'hC7
`define SFEPD_OP_SLEEP 8'hB9
`define SFEPD_OP_WAKE_ID 8'hAB
`define SFEPD_OP_MAKER_PART 8'h90
`define SFEPD_OP_IDENT 8'h9F
`define SFEPD_OP_UNIQUE 8'h4B
`define SFEPD_OP_RESET_EN 8'h66
`define SFEPD_OP_RESET 8'h99

// bit counts at which a frame may end or output may start, and the 9FH ID length
`define SFEPD_OPCODE_BITS 16'h0008
`define SFEPD_ADDR_END_BITS 16'h0020
`define SFEPD_UNIQUE_HDR_BITS 16'h0028
`define SFEPD_IDENT_BITS 16'h0018

// read-out modes
`define SFEPD_RD_NONE 3'h0
`define SFEPD_RD_DEVID 3'h1
`define SFEPD_RD_MAKER 3'h2
`define SFEPD_RD_TRIPLE 3'h3
`define SFEPD_RD_UNIQUE 3'h4

// erase kinds reported with the start pulse
`define SFEPD_KIND_SMALL 2'h1
`define SFEPD_KIND_LARGE 2'h2
`define SFEPD_KIND_WHOLE 2'h3

// clock and times
`define SFEPD_CLK_MHZ 200
`define SFEPD_CLK_KHZ 200000
`define SFEPD_SMALL_BLOCK_WIPE_TIME_MS 100
`define SFEPD_LARGE_BLOCK_WIPE_TIME_MS 200
`define SFEPD_WHOLE_WIPE_TIME_MS 10000
`define SFEPD_SLEEP_ENTRY_DELAY_NS 3000
`define SFEPD_WAKE_RECOVERY_TIME_NS 3000

`endif

// File: sfepd_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module sfepd_pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk,
  input wire rst_n,
  input wire pinIn,
  output reg level_q
);

  reg meta_q;
  reg mid_q;
  reg last_q;

  // three stages; the level moves only once stages two and three agree
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      mid_q <= RESET_VAL;
      last_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      meta_q <= pinIn;
      mid_q <= meta_q;
      last_q <= mid_q;
      if (mid_q == last_q) begin
        level_q <= last_q;
      end
    end
  end

endmodule // sfepd_pin_sync

`default_nettype wire

// File: sfepd_core.v
`timescale 1ns/1ps
`default_nettype none
`include "sfepd_consts.vh"

// Operation
// - small block erase is 52H plus three address bytes; any inner address
// - large block erase is D8H plus three address bytes; any inner address
// - block erase runs only if chip select rises right after bit 32
// - erase is self-timed; busy flag high meanwhile, write latch cleared
// - block erase inside the protected region is not executed
// - chip erase is 60H or C7H alone, select rising after bit 8
// - chip erase only with protect bits all zero/invert 0 or all one/invert 1
// - sleep command B9H enters deep power-down after a fixed delay
// - in deep power-down only wake/ID and software reset are honoured
// - sleep command during an active cycle is rejected
// - deselect gives standby; power-up and reset leave deep power-down clear
// - ABH plus three dummy bytes streams device ID repeatedly, MSB first
// - wake/ID command is ignored while busy
// - 90H plus zero address returns maker ID then device ID
// - 9FH returns maker, memory type, capacity; select rise ends it
// - 9FH is not decoded while an erase is running
// - 4BH, zero address, dummy byte, then 128-bit unique number
// - opcode, address and dummy bits sampled on serial clock rising edges

module sfepd_core #(
  parameter [31:0] SMALL_WIPE_CYC = `SFEPD_SMALL_BLOCK_WIPE_TIME_MS * `SFEPD_CLK_KHZ,
  parameter [31:0] LARGE_WIPE_CYC = `SFEPD_LARGE_BLOCK_WIPE_TIME_MS * `SFEPD_CLK_KHZ,
  parameter [31:0] WHOLE_WIPE_CYC = `SFEPD_WHOLE_WIPE_TIME_MS * `SFEPD_CLK_KHZ,
  parameter ARRAY_BITS = 23,
  parameter [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter [7:0] DEV_ID = 8'h3C, // arbitrary value
  parameter [7:0] MEM_TYPE = 8'h41, // arbitrary value
  parameter [7:0] CAPACITY = 8'h17, // arbitrary value
  parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210 // arbitrary value
) (
  input wire clk,
  input wire rst_n,
  input wire chipSelN,
  input wire serialClk,
  input wire serialIn,
  output reg serialOut,
  output reg serialOutEn,
  input wire [4:0] protectField,
  input wire protectInvert,
  output reg opInProgress,
  output reg writeLatch,
  output reg sleeping,
  output reg wipeStart,
  output reg [1:0] wipeKind,
  output reg [23:0] wipeAddr
);

  localparam [31:0] SLEEP_ENTRY_CYC =
    (`SFEPD_SLEEP_ENTRY_DELAY_NS * `SFEPD_CLK_MHZ + 999) / 1000;
  localparam [31:0] WAKE_RECOVERY_CYC =
    (`SFEPD_WAKE_RECOVERY_TIME_NS * `SFEPD_CLK_MHZ + 999) / 1000;

  // internal states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WIPE = 3'h1;
  localparam [2:0] ST_SLEEP_ENTRY = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_WAKE = 3'h4;

  wire csSyncN;
  wire sclkSync;
  wire siSync;

  reg csPrev_q;
  reg sclkPrev_q;
  reg [15:0] bitCnt_q;
  reg [31:0] shift_q;
  reg [7:0] opcode_q;
  reg [2:0] rdMode_q;
  reg outActive_q;
  reg [2:0] state_q;
  reg [31:0] timer_q;
  reg rstEn_q;

  // pins from the host pass the three-stage filter
  sfepd_pin_sync #(.RESET_VAL(1'b1)) csSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(chipSelN),
    .level_q(csSyncN)
  );

  sfepd_pin_sync #(.RESET_VAL(1'b0)) sclkSyncInst (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(serialClk),
    .level_q(sclkSync)
  );

  sfepd_pin_sync #(.RESET_VAL(1'b0)) siSyncInst (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(serialIn),
    .level_q(siSync)
  );

  // edge detection on the filtered levels
  wire csRise = csSyncN & ~csPrev_q;
  wire sclkRise = ~csSyncN & sclkSync & ~sclkPrev_q;
  wire sclkFall = ~csSyncN & ~sclkSync & sclkPrev_q;

  // opcode as it completes on the eighth rising edge
  wire [7:0] opNow = {shift_q[6:0], siSync};
  wire [23:0] addrIn = shift_q[23:0];

  // protected region: units of 1/64 of the array at top or bottom
  function isProtected;
    input [23:0] addr;
    input [4:0] bp;
    input inv;
    reg [6:0] unit;
    reg [6:0] span;
    reg inRange;
    begin
      unit = {1'b0, addr[ARRAY_BITS-1 -: 6]};
      if (bp[2:0] == 3'h0) begin
        span = 7'h00;
      end else if (bp[2:0] == 3'h7) begin
        span = 7'h40;
      end else begin
        span = 7'h01 << (bp[2:0] - 3'h1);
      end
      if (bp[3]) begin
        inRange = unit < span;
      end else begin
        inRange = unit >= (7'h40 - span);
      end
      isProtected = inRange ^ inv;
    end
  endfunction

  // header length ahead of the first output bit
  function [15:0] hdrOf;
    input [2:0] mode;
    begin
      case (mode)
        `SFEPD_RD_TRIPLE: hdrOf = `SFEPD_OPCODE_BITS;
        `SFEPD_RD_UNIQUE: hdrOf = `SFEPD_UNIQUE_HDR_BITS;
        default: hdrOf = `SFEPD_ADDR_END_BITS;
      endcase
    end
  endfunction

  // output bit for a given index within the read-out stream
  function idBit;
    input [2:0] mode;
    input [15:0] idx;
    reg [15:0] pair;
    reg [23:0] triple;
    begin
      pair = {MAKER_ID, DEV_ID};
      triple = {MAKER_ID, MEM_TYPE, CAPACITY};
      case (mode)
        `SFEPD_RD_DEVID: idBit = DEV_ID[~idx[2:0]];
        `SFEPD_RD_MAKER: idBit = pair[~idx[3:0]];
        `SFEPD_RD_TRIPLE: begin
          if (idx < `SFEPD_IDENT_BITS) begin
            idBit = triple[5'd23 - idx[4:0]];
          end else begin
            idBit = 1'b0;
          end
        end
        `SFEPD_RD_UNIQUE: idBit = UNIQUE_ID[~idx[6:0]];
        default: idBit = 1'b0;
      endcase
    end
  endfunction

  wire [15:0] curHdr = hdrOf(rdMode_q);
  wire [15:0] outIdx = bitCnt_q - curHdr;
  wire idleNow = (state_q == ST_IDLE);
  wire frameAtOp = (bitCnt_q == `SFEPD_OPCODE_BITS);
  wire frameAtAddr = (bitCnt_q == `SFEPD_ADDR_END_BITS);
  wire chipOk = ((protectField[2:0] == 3'h0) && !protectInvert) ||
                ((protectField[2:0] == 3'h7) && protectInvert);

  // edge history and input shifting on rising serial clock
  always @(posedge clk) begin
    if (!rst_n) begin
      csPrev_q <= 1'b1;
      sclkPrev_q <= 1'b0;
      bitCnt_q <= 16'h0000;
      shift_q <= 32'h00000000;
      opcode_q <= 8'h00;
    end else begin
      csPrev_q <= csSyncN;
      sclkPrev_q <= sclkSync;
      if (csSyncN) begin
        bitCnt_q <= 16'h0000;
      end else if (sclkRise) begin
        shift_q <= {shift_q[30:0], siSync};
        bitCnt_q <= bitCnt_q + 16'h0001;
        if (bitCnt_q == 16'h0007) begin
          opcode_q <= opNow;
        end
      end
    end
  end

  // read-out selection on rising and serial output on falling serial clock
  always @(posedge clk) begin
    if (!rst_n) begin
      rdMode_q <= `SFEPD_RD_NONE;
      outActive_q <= 1'b0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (csSyncN) begin
      rdMode_q <= `SFEPD_RD_NONE;
      outActive_q <= 1'b0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      if (sclkRise && bitCnt_q == 16'h0007) begin
        case (opNow)
          `SFEPD_OP_WAKE_ID: begin
            if (idleNow || state_q == ST_SLEEP) begin
              rdMode_q <= `SFEPD_RD_DEVID;
            end
          end
          `SFEPD_OP_MAKER_PART: begin
            if (idleNow) begin
              rdMode_q <= `SFEPD_RD_MAKER;
            end
          end
          `SFEPD_OP_IDENT: begin
            if (idleNow) begin
              rdMode_q <= `SFEPD_RD_TRIPLE;
            end
          end
          `SFEPD_OP_UNIQUE: begin
            if (idleNow) begin
              rdMode_q <= `SFEPD_RD_UNIQUE;
            end
          end
          default: rdMode_q <= `SFEPD_RD_NONE;
        endcase
      end
      if (sclkFall && rdMode_q != `SFEPD_RD_NONE && (outActive_q || bitCnt_q == curHdr)) begin
        outActive_q <= 1'b1;
        serialOut <= idBit(rdMode_q, outIdx);
        serialOutEn <= 1'b1;
      end
    end
  end

  // command execution at the rise of chip select, and internal timing
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h00000000;
      rstEn_q <= 1'b0;
      writeLatch <= 1'b0;
      opInProgress <= 1'b0;
      sleeping <= 1'b0;
      wipeStart <= 1'b0;
      wipeKind <= 2'h0;
      wipeAddr <= 24'h000000;
    end else begin
      wipeStart <= 1'b0;
      if (csRise) begin
        rstEn_q <= frameAtOp && opcode_q == `SFEPD_OP_RESET_EN;
      end
      if (csRise && frameAtOp && opcode_q == `SFEPD_OP_RESET && rstEn_q) begin
        // software reset ends any cycle and deep power-down
        state_q <= ST_IDLE;
        timer_q <= 32'h00000000;
        writeLatch <= 1'b0;
        opInProgress <= 1'b0;
        sleeping <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (csRise && frameAtOp && opcode_q == `SFEPD_OP_LATCH_SET) begin
              writeLatch <= 1'b1;
            end else if (csRise && frameAtAddr && writeLatch &&
                         (opcode_q == `SFEPD_OP_SMALL_WIPE || opcode_q == `SFEPD_OP_LARGE_WIPE)) begin
              if (!isProtected(addrIn, protectField, protectInvert)) begin
                state_q <= ST_WIPE;
                opInProgress <= 1'b1;
                writeLatch <= 1'b0;
                wipeStart <= 1'b1;
                if (opcode_q == `SFEPD_OP_SMALL_WIPE) begin
                  timer_q <= SMALL_WIPE_CYC - 32'h00000001;
                  wipeKind <= `SFEPD_KIND_SMALL;
                  wipeAddr <= {addrIn[23:15], 15'h0000};
                end else begin
                  timer_q <= LARGE_WIPE_CYC - 32'h00000001;
                  wipeKind <= `SFEPD_KIND_LARGE;
                  wipeAddr <= {addrIn[23:16], 16'h0000};
                end
              end
            end else if (csRise && frameAtOp && writeLatch && chipOk &&
                         (opcode_q == `SFEPD_OP_WHOLE_WIPE_A || opcode_q == `SFEPD_OP_WHOLE_WIPE_B)) begin
              state_q <= ST_WIPE;
              opInProgress <= 1'b1;
              writeLatch <= 1'b0;
              wipeStart <= 1'b1;
              timer_q <= WHOLE_WIPE_CYC - 32'h00000001;
              wipeKind <= `SFEPD_KIND_WHOLE;
              wipeAddr <= 24'h000000;
            end else if (csRise && frameAtOp && opcode_q == `SFEPD_OP_SLEEP) begin
              state_q <= ST_SLEEP_ENTRY;
              timer_q <= SLEEP_ENTRY_CYC - 32'h00000001;
            end
          end
          ST_WIPE: begin
            // sleep and wake commands fall through here unheard
            if (timer_q == 32'h00000000) begin
              state_q <= ST_IDLE;
              opInProgress <= 1'b0;
            end else begin
              timer_q <= timer_q - 32'h00000001;
            end
          end
          ST_SLEEP_ENTRY: begin
            if (timer_q == 32'h00000000) begin
              state_q <= ST_SLEEP;
              sleeping <= 1'b1;
            end else begin
              timer_q <= timer_q - 32'h00000001;
            end
          end
          ST_SLEEP: begin
            if (csRise && bitCnt_q >= `SFEPD_OPCODE_BITS && opcode_q == `SFEPD_OP_WAKE_ID) begin
              state_q <= ST_WAKE;
              timer_q <= WAKE_RECOVERY_CYC - 32'h00000001;
            end
          end
          ST_WAKE: begin
            if (timer_q == 32'h00000000) begin
              state_q <= ST_IDLE;
              sleeping <= 1'b0;
            end else begin
              timer_q <= timer_q - 32'h00000001;
            end
          end
          default: begin
            state_q <= ST_IDLE;
            opInProgress <= 1'b0;
            sleeping <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // sfepd_core

`default_nettype wire

// File: sfepd_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfepd_core_sva #(
  parameter [31:0] WHOLE_WIPE_CYC = 32'h00000032
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic [4:0] protectField,
  input wire logic protectInvert,
  input wire logic opInProgress,
  input wire logic writeLatch,
  input wire logic sleeping,
  input wire logic wipeStart,
  input wire logic [1:0] wipeKind,
  input wire logic [23:0] wipeAddr
);
  logic [31:0] busyCnt_q;
  // length of the current busy period
  always @(posedge clk) begin
    if (!rst_n || !opInProgress) busyCnt_q <= 32'h0;
    else busyCnt_q <= busyCnt_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_one_cycle: assert property (wipeStart |=> !wipeStart)
    else $error("erase start pulse too long");
  a_start_sets_busy: assert property (wipeStart |-> opInProgress && !writeLatch)
    else $error("busy or latch wrong at erase start");
  a_start_needs_latch: assert property (wipeStart |-> $past(writeLatch))
    else $error("erase started without write latch");
  a_start_from_idle: assert property (wipeStart |-> !$past(opInProgress) && !sleeping)
    else $error("erase started while busy or asleep");
  a_chip_addr_zero: assert property (wipeStart && wipeKind == 2'h3 |-> wipeAddr == 24'h0)
    else $error("chip erase address not zero");
  a_small_aligned: assert property (wipeStart && wipeKind == 2'h1 |-> wipeAddr[14:0] == 15'h0)
    else $error("small block address not aligned");
  a_large_aligned: assert property (wipeStart && wipeKind == 2'h2 |-> wipeAddr[15:0] == 16'h0)
    else $error("large block address not aligned");
  a_busy_bounded: assert property (busyCnt_q <= WHOLE_WIPE_CYC + 32'h8)
    else $error("busy flag stuck");
  a_no_out_busy: assert property ($rose(serialOutEn) |-> !opInProgress)
    else $error("id output while busy");
  a_out_idle_low: assert property (!serialOutEn |-> !serialOut)
    else $error("data out without enable");
  a_sleep_not_busy: assert property (sleeping |-> !opInProgress)
    else $error("asleep while busy");
  cover property (wipeStart && wipeKind == 2'h3);
  cover property ($rose(sleeping));
  cover property ($rose(serialOutEn));
endmodule // sfepd_core_sva
bind sfepd_core sfepd_core_sva #(.WHOLE_WIPE_CYC(WHOLE_WIPE_CYC)) sfepd_core_sva_i (.clk(clk), .rst_n(rst_n),
  .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .protectField(protectField), .protectInvert(protectInvert),
  .opInProgress(opInProgress), .writeLatch(writeLatch), .sleeping(sleeping), .wipeStart(wipeStart),
  .wipeKind(wipeKind), .wipeAddr(wipeAddr));
`default_nettype wire

// File: sfepd_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfepd_host (
  input wire logic clk,
  output var logic chipSelN,
  output var logic serialClk,
  output var logic serialIn,
  input wire logic serialOut
);
  // idle bus: deselected, clock parked low
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // one frame of 48 ns clock periods, tx sent from bit 255 down, rx taken just before each rise
  task automatic xfer(input logic [255:0] tx, input int n, output logic [255:0] rx);
    rx = 256'h0;
    @(negedge clk);
    chipSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialIn = tx[255 - i];
      #28;
      rx = {rx[254:0], serialOut};
      serialClk = 1'b1;
      #20;
      serialClk = 1'b0;
    end
    repeat (6) @(negedge clk);
    chipSelN = 1'b1;
    serialIn = ~serialIn; // released line does not keep its value
    repeat (12) @(negedge clk);
  endtask
endmodule // sfepd_host
`default_nettype wire

// File: serial_flash_erase_powerdown_id_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_powerdown_id_test;
  localparam logic [7:0] Mk = 8'hC3, Dv = 8'h2E, Mt = 8'h71, Cp = 8'h16;
  localparam logic [127:0] Uid = 128'hA5A50F0F123456789ABCDEF00FEDCBA9;
  localparam logic [31:0] Whole = 32'h00000BB8;
  logic clk, rst_n, chipSelN, serialClk, serialIn, serialOut, serialOutEn;
  logic opInProgress, writeLatch, sleeping, wipeStart, protectInvert;
  logic [4:0] protectField;
  logic [1:0] wipeKind, lastKind;
  logic [23:0] wipeAddr, lastAddr;
  logic [255:0] rxData;
  int num_errors = 0, checks_done = 0, cycleCount = 0, startCnt = 0;
  sfepd_core #(.SMALL_WIPE_CYC(32'h32), .LARGE_WIPE_CYC(32'h32), .WHOLE_WIPE_CYC(Whole), .MAKER_ID(Mk),
    .DEV_ID(Dv), .MEM_TYPE(Mt), .CAPACITY(Cp), .UNIQUE_ID(Uid)) sfepd_core_i (.clk(clk), .rst_n(rst_n),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .protectField(protectField), .protectInvert(protectInvert),
    .opInProgress(opInProgress), .writeLatch(writeLatch), .sleeping(sleeping), .wipeStart(wipeStart),
    .wipeKind(wipeKind), .wipeAddr(wipeAddr));
  sfepd_host sfepd_host_i (.clk(clk), .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn),
    .serialOut(serialOut));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // erase starts and hang guard
  always @(negedge clk) begin
    cycleCount++;
    if (wipeStart === 1'b1) begin
      startCnt++;
      lastKind = wipeKind;
      lastAddr = wipeAddr;
    end
    if (cycleCount == 40000) begin
      num_errors++;
      print_verdict;
    end
  end
  task print_verdict;
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmd(input logic [7:0] op, input logic [23:0] adr, input int n);
    sfepd_host_i.xfer({op, adr, 224'h0}, n, rxData);
  endtask
  task waitIdle;
    for (int k = 0; k < 4000 && opInProgress !== 1'b0; k++) @(negedge clk);
    chk("busy done", opInProgress, 1'b0);
  endtask
  task erase(input logic [7:0] op, input logic [23:0] adr, input int n, input logic go, input logic [1:0] kind,
    input logic [23:0] exAdr);
    int s;
    cmd(8'h06, 24'h0, 8);
    chk("writeLatch", writeLatch, 1'b1);
    s = startCnt;
    cmd(op, adr, n);
    chk("started", startCnt - s, go);
    if (go) begin
      chk("kind", lastKind, kind);
      chk("addr", lastAddr, exAdr);
      chk("latch cleared", writeLatch, 1'b0);
      chk("busy", opInProgress, 1'b1);
    end
  endtask
  task t_reset;
    chk("outputs", {serialOut, serialOutEn, opInProgress, writeLatch, sleeping, wipeStart, wipeKind, wipeAddr},
      32'h0);
  endtask
  task t_ids;
    cmd(8'h9F, 24'h0, 32);
    chk("triplet", rxData[23:0], {Mk, Mt, Cp});
    chk("out released", serialOutEn, 1'b0);
    cmd(8'h90, 24'h0, 48);
    chk("maker part", rxData[15:0], {Mk, Dv});
    cmd(8'hAB, 24'h0, 48);
    chk("dev id", rxData[15:0], {Dv, Dv});
    sfepd_host_i.xfer({8'h4B, 248'h0}, 168, rxData);
    chk("unique", rxData[127:0], Uid);
  endtask
  task t_no_latch;
    int s;
    s = startCnt;
    cmd(8'h52, 24'h0, 32);
    chk("started", startCnt - s, 0);
    chk("status", {writeLatch, opInProgress}, 2'h0);
  endtask
  task t_blocks;
    erase(8'h52, 24'h123456, 32, 1'b1, 2'h1, 24'h120000);
    waitIdle;
    erase(8'hD8, 24'h3FFFFF, 32, 1'b1, 2'h2, 24'h3F0000);
    waitIdle;
    erase(8'hD8, 24'h0, 33, 1'b0, 2'h0, 24'h0);
    erase(8'h52, 24'h0, 31, 1'b0, 2'h0, 24'h0);
  endtask
  task t_protect;
    protectField = 5'h01;
    erase(8'h52, 24'h7F8000, 32, 1'b0, 2'h0, 24'h0);
    erase(8'h52, 24'h0, 32, 1'b1, 2'h1, 24'h0);
    waitIdle;
    erase(8'h60, 24'h0, 8, 1'b0, 2'h0, 24'h0);
    protectField = 5'h07;
    protectInvert = 1'b1;
    erase(8'h60, 24'h0, 8, 1'b1, 2'h3, 24'h0);
    waitIdle;
    protectField = 5'h00;
    protectInvert = 1'b0;
  endtask
  task t_busy;
    erase(8'hC7, 24'h0, 8, 1'b1, 2'h3, 24'h0);
    cmd(8'h9F, 24'h0, 32);
    chk("triplet busy", rxData[23:0], 24'h0);
    cmd(8'hB9, 24'h0, 8);
    repeat (650) @(negedge clk);
    chk("sleep rejected", sleeping, 1'b0);
    cmd(8'hAB, 24'h0, 48);
    chk("dev id busy", rxData[15:0], 16'h0);
    chk("still busy", opInProgress, 1'b1);
    waitIdle;
  endtask
  task t_sleep;
    cmd(8'hB9, 24'h0, 8);
    for (int k = 0; k < 700 && sleeping !== 1'b1; k++) @(negedge clk);
    chk("asleep", sleeping, 1'b1);
    cmd(8'h06, 24'h0, 8);
    chk("latch ignored", writeLatch, 1'b0);
    cmd(8'hAB, 24'h0, 8);
    for (int k = 0; k < 700 && sleeping !== 1'b0; k++) @(negedge clk);
    chk("awake", sleeping, 1'b0);
    cmd(8'h9F, 24'h0, 32);
    chk("triplet awake", rxData[23:0], {Mk, Mt, Cp});
  endtask
  task t_soft_reset;
    cmd(8'hB9, 24'h0, 8);
    for (int k = 0; k < 700 && sleeping !== 1'b1; k++) @(negedge clk);
    chk("asleep again", sleeping, 1'b1);
    cmd(8'h66, 24'h0, 8);
    cmd(8'h99, 24'h0, 8);
    chk("reset wakes", sleeping, 1'b0);
    cmd(8'h9F, 24'h0, 32);
    chk("triplet reset", rxData[23:0], {Mk, Mt, Cp});
  endtask
  task t_rst_mid;
    erase(8'hC7, 24'h0, 8, 1'b1, 2'h3, 24'h0);
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("after reset", {opInProgress, writeLatch, sleeping, serialOutEn}, 4'h0);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    protectField = 5'h00;
    protectInvert = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset;
    t_ids;
    t_no_latch;
    t_blocks;
    t_protect;
    t_busy;
    t_sleep;
    t_soft_reset;
    t_rst_mid;
    print_verdict;
  end
endmodule // serial_flash_erase_powerdown_id_test
`default_nettype wire
